//--- pulse_count_led_programmer.v
// Functional notes
// - rising edges on the enable line are counted to pick address or data.
// - the count latches after the line stays high for the latch timeout.
// - data registers are 4 bits; counts 1 to 16 are data.
// - counts above 16 select address count minus 17.
// - selected address persists after data writes until a new address burst.
// - after shutdown address is 0; data-only burst lights all six sinks.
// - line low longer than the off timeout enters shutdown.
// - shutdown clears the address and all data registers to zero.
// - address 0 data sets all six backlight sinks to one level; the code ignores address 0 in independent mode.
// - address 1 sets the five main sinks only, sub untouched.
// - address 2 sets the single sub sink only; in independent mode the code takes its data bits as enables for sinks 5 to 2.
// - full scale 20mA or 30mA; data 1 full, data 16 zero.
// - pump steps 1X to 1.5X to 2X when an active sink drops out.
// - a sink tied to the pump output is disabled.
// - address 4 sets flash current, data 1 is full maximum.
// - flash off at start; address 5 data 1 off, 2 b, 3 a, 4 both.
// - scale defaults to 20mA; address 12 data 1 is 20mA, 2 is 30mA.
// - address 15 data 8 enters independent mode until shutdown.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "pulse_link_defs.vh"

module pulse_count_led_programmer #(
  parameter LATCH_CYCLES = `LATCH_CYCLES,
  parameter OFF_CYCLES = `OFF_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire serialEnable,
  input wire [7:0] sinkDropout,
  input wire [7:0] sinkTiedOut,
  input wire [4:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [31:0] regRdata,
  output reg [3:0] mainLevel,
  output reg [3:0] subLevel,
  output reg [3:0] lowCurrentCode,
  output reg lowCurrentActive,
  output reg [5:0] backlightSinks,
  output reg scale30mA,
  output reg [3:0] flashLevel,
  output reg flashSinkA,
  output reg flashSinkB,
  output reg independentMode,
  output reg [1:0] pumpMode,
  output reg shutdown
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // edge count 1..16 maps onto the 4-bit register code 0..15
  function [3:0] dataCode;
    input [5:0] edges;
    reg [5:0] tmp;
    begin
      tmp = edges - 6'h01;
      dataCode = tmp[3:0];
    end
  endfunction

  // ----------------------------------------
  // line timing
  // ----------------------------------------
  wire risePulse;
  wire latchPulse;
  wire offPulse;

  line_timer #(
    .LATCH_CYCLES(LATCH_CYCLES),
    .OFF_CYCLES(OFF_CYCLES)
  ) u_line_timer (
    .clk(clk),
    .rst_n(rst_n),
    .lineIn(serialEnable),
    .risePulse(risePulse),
    .latchPulse(latchPulse),
    .offPulse(offPulse)
  );

  // ----------------------------------------
  // edge counter and address latch
  // ----------------------------------------
  reg [5:0] edgeCount_r;
  reg [5:0] linkAddr_r;
  reg dataStrobe_r;
  reg [3:0] dataValue_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCount_r <= 6'h00;
      linkAddr_r <= `RST_LADDR;
      dataStrobe_r <= 1'b0;
      dataValue_r <= `RST_LEVEL;
    end else begin
      dataStrobe_r <= 1'b0;
      if (offPulse) begin
        edgeCount_r <= 6'h00;
        linkAddr_r <= `RST_LADDR;
        dataValue_r <= `RST_LEVEL;
      end else if (latchPulse) begin
        edgeCount_r <= 6'h00;
        if (edgeCount_r > `DATA_MAX_EDGES) begin
          linkAddr_r <= edgeCount_r - `ADDR_BASE_EDGES;
        end else if (edgeCount_r != 6'h00) begin
          // address kept as is, so repeated data bursts reuse it
          dataStrobe_r <= 1'b1;
          dataValue_r <= dataCode(edgeCount_r);
        end
      end else if (risePulse && edgeCount_r != `EDGE_COUNT_MAX) begin
        // saturates; no legal burst gets near the top
        edgeCount_r <= edgeCount_r + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // setting registers
  // ----------------------------------------
  reg [3:0] mainLevel_r;
  reg [3:0] subLevel_r;
  reg [3:0] lowCode_r;
  reg lowActive_r;
  reg [5:0] blEnable_r;
  reg scale30_r;
  reg [3:0] flashLevel_r;
  reg [1:0] flashOn_r;
  reg indep_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mainLevel_r <= `RST_LEVEL;
      subLevel_r <= `RST_LEVEL;
      lowCode_r <= `RST_LEVEL;
      lowActive_r <= 1'b0;
      blEnable_r <= 6'h00;
      scale30_r <= 1'b0;
      flashLevel_r <= `RST_LEVEL;
      flashOn_r <= 2'h0;
      indep_r <= 1'b0;
    end else if (offPulse) begin
      mainLevel_r <= `RST_LEVEL;
      subLevel_r <= `RST_LEVEL;
      lowCode_r <= `RST_LEVEL;
      lowActive_r <= 1'b0;
      blEnable_r <= 6'h00;
      scale30_r <= 1'b0;
      flashLevel_r <= `RST_LEVEL;
      flashOn_r <= 2'h0;
      indep_r <= 1'b0;
    end else if (dataStrobe_r) begin
      case (linkAddr_r)
        `LADDR_ALL: begin
          if (!indep_r) begin
            mainLevel_r <= dataValue_r;
            subLevel_r <= dataValue_r;
            blEnable_r <= 6'h3f;
            lowActive_r <= 1'b0;
          end
        end
        `LADDR_MAIN: begin
          mainLevel_r <= dataValue_r;
          blEnable_r[4:0] <= 5'h1f;
          lowActive_r <= 1'b0;
        end
        `LADDR_SUB: begin
          if (indep_r) begin
            blEnable_r[5:2] <= dataValue_r;
          end else begin
            subLevel_r <= dataValue_r;
            blEnable_r[5] <= 1'b1;
            lowActive_r <= 1'b0;
          end
        end
        `LADDR_LOW: begin
          if (indep_r) begin
            blEnable_r[1:0] <= {dataValue_r[3], dataValue_r[2]};
          end else begin
            // code 0..3 keeps both groups dark, bit 3 main, bit 2 sub
            lowCode_r <= dataValue_r;
            lowActive_r <= 1'b1;
            blEnable_r <= {dataValue_r[2], {5{dataValue_r[3]}}};
          end
        end
        `LADDR_FLASH_LEVEL: begin
          flashLevel_r <= dataValue_r;
        end
        `LADDR_FLASH_ON: begin
          case (dataValue_r)
            `CODE_FLASH_NONE: flashOn_r <= 2'h0;
            `CODE_FLASH_B: flashOn_r <= 2'h2;
            `CODE_FLASH_A: flashOn_r <= 2'h1;
            `CODE_FLASH_BOTH: flashOn_r <= 2'h3;
            default: flashOn_r <= flashOn_r;
          endcase
        end
        `LADDR_SCALE: begin
          if (dataValue_r == `CODE_SCALE_20) begin
            scale30_r <= 1'b0;
          end else if (dataValue_r == `CODE_SCALE_30) begin
            scale30_r <= 1'b1;
          end
        end
        `LADDR_INDEP: begin
          if (dataValue_r == `CODE_INDEP_ON) begin
            indep_r <= 1'b1;
          end
        end
        default: begin
          indep_r <= indep_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // sink gating
  // ----------------------------------------
  // flash a = bit 6, flash b = bit 7 in the sink vectors
  wire [7:0] sinkRequest;
  wire [7:0] sinkActive;
  assign sinkRequest = {flashOn_r[1], flashOn_r[0], blEnable_r};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sink
      // a sink strapped to the pump output is unused or shorted
      assign sinkActive[gi] = sinkRequest[gi] & ~sinkTiedOut[gi];
    end
  endgenerate

  // ----------------------------------------
  // pump mode
  // ----------------------------------------
  // stepping down needs the analog supply comparison; software relaxes it
  reg [1:0] pump_r;
  reg relaxReq_r;
  wire anyDropout;
  assign anyDropout = |(sinkDropout & sinkActive);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_r <= `PUMP_1X;
    end else if (offPulse || relaxReq_r) begin
      pump_r <= `PUMP_1X;
    end else if (anyDropout) begin
      case (pump_r)
        `PUMP_1X: pump_r <= `PUMP_1P5X;
        `PUMP_1P5X: pump_r <= `PUMP_2X;
        default: pump_r <= `PUMP_2X;
      endcase
    end
  end

  // ----------------------------------------
  // shutdown state
  // ----------------------------------------
  reg shutdown_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_r <= 1'b1;
    end else if (offPulse) begin
      shutdown_r <= 1'b1;
    end else if (risePulse) begin
      shutdown_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mainLevel <= `RST_LEVEL;
      subLevel <= `RST_LEVEL;
      lowCurrentCode <= `RST_LEVEL;
      lowCurrentActive <= 1'b0;
      backlightSinks <= 6'h00;
      scale30mA <= 1'b0;
      flashLevel <= `RST_LEVEL;
      flashSinkA <= 1'b0;
      flashSinkB <= 1'b0;
      independentMode <= 1'b0;
      pumpMode <= `PUMP_1X;
      shutdown <= 1'b1;
    end else begin
      mainLevel <= mainLevel_r;
      subLevel <= subLevel_r;
      lowCurrentCode <= lowCode_r;
      lowCurrentActive <= lowActive_r;
      backlightSinks <= sinkActive[5:0];
      scale30mA <= scale30_r;
      flashLevel <= flashLevel_r;
      flashSinkA <= sinkActive[6];
      flashSinkB <= sinkActive[7];
      independentMode <= indep_r;
      pumpMode <= pump_r;
      shutdown <= shutdown_r;
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relaxReq_r <= 1'b0;
    end else begin
      relaxReq_r <= regWrite && regAddr == `REG_CONTROL &&
                    regWdata[`CTRL_PUMP_RELAX_BIT];
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        `REG_STATUS: regRdata <= {16'h0000, pump_r, indep_r, shutdown_r,
                                  edgeCount_r, linkAddr_r};
        `REG_LEVELS: regRdata <= {16'h0000, lowActive_r, 3'h0, lowCode_r,
                                  subLevel_r, mainLevel_r};
        `REG_FLASH: regRdata <= {24'h000000, scale30_r, 1'b0, flashOn_r,
                                 flashLevel_r};
        `REG_SINKS: regRdata <= {24'h000000, sinkActive};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule // pulse_count_led_programmer

//--- pulse_link_defs.vh
`ifndef PULSE_LINK_DEFS_VH
`define PULSE_LINK_DEFS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define LATCH_TIMEOUT_NS 500000
`define OFF_TIMEOUT_NS 500000
`define LATCH_CYCLES (`LATCH_TIMEOUT_NS / `CLK_PERIOD_NS)
`define OFF_CYCLES (`OFF_TIMEOUT_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// edge counting
// ----------------------------------------
`define DATA_MAX_EDGES 6'h10
`define ADDR_BASE_EDGES 6'h11
`define EDGE_COUNT_MAX 6'h3f

// ----------------------------------------
// link addresses
// ----------------------------------------
`define LADDR_ALL 6'h00
`define LADDR_MAIN 6'h01
`define LADDR_SUB 6'h02
`define LADDR_LOW 6'h03
`define LADDR_FLASH_LEVEL 6'h04
`define LADDR_FLASH_ON 6'h05
`define LADDR_SCALE 6'h0c
`define LADDR_INDEP 6'h0f

// ----------------------------------------
// data codes (edge count minus one)
// ----------------------------------------
`define CODE_FLASH_NONE 4'h0
`define CODE_FLASH_B 4'h1
`define CODE_FLASH_A 4'h2
`define CODE_FLASH_BOTH 4'h3
`define CODE_SCALE_20 4'h0
`define CODE_SCALE_30 4'h1
`define CODE_INDEP_ON 4'h7

// ----------------------------------------
// pump modes
// ----------------------------------------
`define PUMP_1X 2'h0
`define PUMP_1P5X 2'h1
`define PUMP_2X 2'h2

// ----------------------------------------
// software register map (byte addresses)
// ----------------------------------------
`define REG_STATUS 5'h00
`define REG_LEVELS 5'h04
`define REG_FLASH 5'h08
`define REG_SINKS 5'h0c
`define REG_CONTROL 5'h10
`define CTRL_PUMP_RELAX_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_LEVEL 4'h0
`define RST_LADDR 6'h00
`define RST_SINKS 8'h00

`endif

//--- line_timer.v
`timescale 1ns/1ps
`include "pulse_link_defs.vh"

module line_timer #(
  parameter LATCH_CYCLES = `LATCH_CYCLES,
  parameter OFF_CYCLES = `OFF_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire lineIn,
  output reg risePulse,
  output reg latchPulse,
  output reg offPulse
);

  reg lineLast_r;
  reg [15:0] highCnt_r;
  reg [15:0] lowCnt_r;

  // ----------------------------------------
  // edge and level timing
  // ----------------------------------------
  // counters stop at their limit so each pulse fires once per level period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineLast_r <= 1'b0;
      highCnt_r <= 16'h0000;
      lowCnt_r <= 16'h0000;
      risePulse <= 1'b0;
      latchPulse <= 1'b0;
      offPulse <= 1'b0;
    end else begin
      lineLast_r <= lineIn;
      risePulse <= lineIn & ~lineLast_r;
      latchPulse <= 1'b0;
      offPulse <= 1'b0;
      if (lineIn) begin
        lowCnt_r <= 16'h0000;
        if (!lineLast_r) begin
          highCnt_r <= 16'h0001;
        end else if (highCnt_r < LATCH_CYCLES[15:0]) begin
          highCnt_r <= highCnt_r + 16'h0001;
          if (highCnt_r == LATCH_CYCLES[15:0] - 16'h0001) begin
            latchPulse <= 1'b1;
          end
        end
      end else begin
        highCnt_r <= 16'h0000;
        if (lowCnt_r <= OFF_CYCLES[15:0]) begin
          lowCnt_r <= lowCnt_r + 16'h0001;
          if (lowCnt_r == OFF_CYCLES[15:0]) begin
            offPulse <= 1'b1;
          end
        end
      end
    end
  end

endmodule // line_timer

//--- pulse_link_properties.sv
`timescale 1ns/1ps
module pulse_link_properties #(
  parameter int LATCH_CYCLES = 20,
  parameter int OFF_CYCLES = 30
) (
  input wire clk,
  input wire rst_n,
  input wire serialEnable,
  input wire [7:0] sinkTiedOut,
  input wire [3:0] mainLevel,
  input wire [3:0] subLevel,
  input wire [3:0] flashLevel,
  input wire [5:0] backlightSinks,
  input wire scale30mA,
  input wire flashSinkA,
  input wire flashSinkB,
  input wire independentMode,
  input wire [1:0] pumpMode,
  input wire shutdown
);
  reg [15:0] lowCnt_r;
  reg [15:0] highCnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // saturating run lengths of the enable line
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_r <= 16'h0;
      highCnt_r <= 16'h0;
    end else begin
      lowCnt_r <= serialEnable ? 16'h0 : lowCnt_r + {15'h0, lowCnt_r != 16'hffff};
      highCnt_r <= !serialEnable ? 16'h0 : highCnt_r + {15'h0, highCnt_r != 16'hffff};
    end
  end
  AST_OFF_SHUTDOWN: assert property (lowCnt_r > OFF_CYCLES + 5 |-> shutdown)
    else $error("line held low but no shutdown");
  AST_SHUTDOWN_CAUSE: assert property ($rose(shutdown) |-> lowCnt_r > OFF_CYCLES)
    else $error("shutdown without a long low");
  AST_SHUTDOWN_CLEAR: assert property (lowCnt_r > OFF_CYCLES + 5 |-> mainLevel == 4'h0
    && subLevel == 4'h0 && flashLevel == 4'h0 && backlightSinks == 6'h0)
    else $error("settings not cleared in shutdown");
  AST_SHUTDOWN_DEFAULTS: assert property (shutdown [*4] |-> !scale30mA && !flashSinkA
    && !flashSinkB && !independentMode)
    else $error("defaults wrong in shutdown");
  AST_TIED_SINK_OFF: assert property (sinkTiedOut == $past(sinkTiedOut)
    && sinkTiedOut == $past(sinkTiedOut, 2) |-> (backlightSinks & sinkTiedOut[5:0]) == 6'h0
    && !(flashSinkA && sinkTiedOut[6]) && !(flashSinkB && sinkTiedOut[7]))
    else $error("tied sink still enabled");
  AST_PUMP_STEP: assert property (pumpMode > $past(pumpMode) |->
    pumpMode == $past(pumpMode) + 2'h1 && pumpMode != 2'h3)
    else $error("pump mode skipped a step");
  AST_LATCH_WAIT: assert property (mainLevel != $past(mainLevel) |->
    highCnt_r >= LATCH_CYCLES || lowCnt_r > OFF_CYCLES)
    else $error("level changed before latch timeout");
  AST_INDEP_HOLD: assert property ($fell(independentMode) |-> lowCnt_r > OFF_CYCLES)
    else $error("independent mode left without shutdown");
  cover property ($rose(pumpMode == 2'h2));
  cover property ($fell(shutdown));
  cover property ($rose(independentMode));
  cover property ($rose(flashSinkA && flashSinkB));
endmodule // pulse_link_properties

bind pulse_count_led_programmer pulse_link_properties #(.LATCH_CYCLES(LATCH_CYCLES),
  .OFF_CYCLES(OFF_CYCLES)) chk (.clk(clk), .rst_n(rst_n), .serialEnable(serialEnable),
  .sinkTiedOut(sinkTiedOut), .mainLevel(mainLevel), .subLevel(subLevel),
  .flashLevel(flashLevel), .backlightSinks(backlightSinks), .scale30mA(scale30mA),
  .flashSinkA(flashSinkA), .flashSinkB(flashSinkB), .independentMode(independentMode),
  .pumpMode(pumpMode), .shutdown(shutdown));

//--- host_line_model.sv
`timescale 1ns/1ps
module host_line_model #(
  parameter int LATCH_CYCLES = 20,
  parameter int OFF_CYCLES = 30
) (
  input wire logic clk,
  output logic serialEnable
);
  initial serialEnable = 1'b0;
  // low phase kept above the receiver's minimum low time
  task automatic burst(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      serialEnable <= 1'b0;
      repeat (8) @(posedge clk);
      serialEnable <= 1'b1;
      repeat (2) @(posedge clk);
    end
    repeat (LATCH_CYCLES + 8) @(posedge clk);
  endtask
  task automatic send(input int a, input int d);
    burst(a + 17);
    burst(d);
  endtask
  task automatic shutOff;
    @(posedge clk);
    serialEnable <= 1'b0;
    repeat (OFF_CYCLES + 8) @(posedge clk);
  endtask
endmodule // host_line_model

//--- pulse_count_led_programmer_bench.sv
`timescale 1ns/1ps
module pulse_count_led_programmer_bench;
  logic clk, rst_n, serialEnable, regWrite, regRead, rdFlag;
  logic [7:0] sinkDropout, sinkTiedOut;
  logic [4:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [3:0] mainLevel, subLevel, flashLevel, lowCurrentCode;
  logic scale30mA, flashSinkA, flashSinkB, independentMode, shutdown, lowCurrentActive;
  logic [5:0] backlightSinks;
  logic [1:0] pumpMode;
  logic [63:0] expQ[$];
  int fails, tests_run, d, codes[4];
  pulse_count_led_programmer #(.LATCH_CYCLES(20), .OFF_CYCLES(30)) dut (.clk(clk),
    .rst_n(rst_n), .serialEnable(serialEnable), .sinkDropout(sinkDropout),
    .sinkTiedOut(sinkTiedOut), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .mainLevel(mainLevel), .subLevel(subLevel),
    .lowCurrentCode(lowCurrentCode), .lowCurrentActive(lowCurrentActive),
    .backlightSinks(backlightSinks),
    .scale30mA(scale30mA), .flashLevel(flashLevel), .flashSinkA(flashSinkA),
    .flashSinkB(flashSinkB), .independentMode(independentMode), .pumpMode(pumpMode),
    .shutdown(shutdown));
  // host timing defaults already match the short sim timeouts
  host_line_model host (.clk(clk),
    .serialEnable(serialEnable));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic regWr(input logic [4:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  // masked expectation queued; the monitor compares when data stands
  task automatic regRd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    expQ.push_back({m, e});
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  task automatic waitPump(input logic [1:0] m);
    int n;
    n = 0;
    while (pumpMode !== m && n < 200) begin
      @(posedge clk);
      n++;
    end
    check({30'h0, pumpMode}, {30'h0, m});
    if (n == 200) test_done();
  endtask
  always @(posedge clk) rdFlag <= regRead;
  always @(negedge clk) begin
    logic [63:0] e;
    if (rdFlag) begin
      e = expQ.pop_front();
      check(regRdata & e[63:32], e[31:0]);
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    $display("wrong value at %0t: run did not finish", $time);
    test_done();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    {regWrite, regRead, regAddr, regWdata, sinkDropout, sinkTiedOut} = '0;
    fails = 0;
    tests_run = 0;
    codes = '{2, 3, 4, 1};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    d = $urandom(95);
    @(posedge clk);
    regRd(5'h00, 32'h1fff, 32'h1000);
    regRd(5'h08, 32'hff, 32'h0);
    host.burst(5);
    regRd(5'h04, 32'hff, 32'h44);
    regRd(5'h00, 32'h1fff, 32'h0);
    check({26'h0, backlightSinks}, 32'h3f);
    sinkTiedOut <= 8'h01;
    repeat (4) @(posedge clk);
    check({26'h0, backlightSinks}, 32'h3e);
    regRd(5'h0c, 32'hff, 32'h3e);
    sinkTiedOut <= 8'h00;
    sinkDropout <= 8'h02;
    @(posedge clk);
    sinkDropout <= 8'h00;
    waitPump(2'h1);
    sinkDropout <= 8'h04;
    @(posedge clk);
    sinkDropout <= 8'h00;
    waitPump(2'h2);
    regWr(5'h10, $urandom | 32'h1);
    waitPump(2'h0);
    d = $urandom_range(16, 1);
    host.send(1, d);
    regRd(5'h04, 32'hff, {24'h4, 4'(d - 1)});
    host.burst(16);
    regRd(5'h04, 32'hff, 32'h4f);
    regRd(5'h00, 32'h3f, 32'h1);
    host.send(2, 1);
    regRd(5'h04, 32'hff, 32'h0f);
    host.send(4, 6);
    regRd(5'h08, 32'h0f, 32'h5);
    host.burst(1);
    regRd(5'h08, 32'h0f, 32'h0);
    for (int i = 0; i < 4; i++) begin
      if (i == 0) host.send(5, codes[i]);
      else host.burst(codes[i]);
      check({flashSinkA, flashSinkB}, {codes[i] >= 3, codes[i] == 2 || codes[i] == 4});
    end
    host.send(12, 2);
    check({31'h0, scale30mA}, 32'h1);
    host.burst(1);
    check({31'h0, scale30mA}, 32'h0);
    host.send(7, 5);
    regRd(5'h04, 32'hff, 32'h0f);
    regRd(5'h14, 32'hffffffff, 32'h0);
    host.send(3, 10);
    check({lowCurrentActive, lowCurrentCode, backlightSinks}, {1'b1, 4'h9, 6'h1f});
    regRd(5'h04, 32'h8fff, 32'h890f);
    host.send(15, 8);
    check({31'h0, independentMode}, 32'h1);
    host.send(2, 11);
    check({26'h0, backlightSinks}, 32'h2b);
    host.send(3, 5);
    check({26'h0, backlightSinks}, 32'h29);
    host.send(0, 3);
    regRd(5'h04, 32'hff, 32'h0f);
    check({26'h0, backlightSinks}, 32'h29);
    host.shutOff();
    regRd(5'h00, 32'h1fff, 32'h1000);
    regRd(5'h04, 32'h8fff, 32'h0);
    check({31'h0, independentMode}, 32'h0);
    host.burst(3);
    regRd(5'h04, 32'hff, 32'h22);
    test_done();
  end
endmodule // pulse_count_led_programmer_bench
